/* File: include/psms_pkg.sv */
// Package for the serial management port slave.
// Assumes a 50 MHz system clock and a controller-driven management clock.
package psms_pkg;
    // ==========================================================
    // Frame layout
    localparam logic [1:0] PSMS_START_PAT  = 2'h1;   // Zero then one
    localparam logic [1:0] PSMS_OP_READ    = 2'h2;
    localparam logic [1:0] PSMS_OP_WRITE   = 2'h1;
    localparam logic [1:0] PSMS_C45_START  = 2'h0;   // Extended frame start
    localparam logic [1:0] PSMS_C45_ADDR   = 2'h0;
    localparam logic [1:0] PSMS_C45_WRITE  = 2'h1;
    localparam logic [1:0] PSMS_C45_RDINC  = 2'h2;
    localparam logic [1:0] PSMS_C45_READ   = 2'h3;
    localparam int         PSMS_HDR_BITS   = 14;     // Start, op, phy, reg
    localparam int         PSMS_DATA_BITS  = 16;
    localparam int         PSMS_REG_NUM    = 32;
    localparam int         PSMS_REG_AW     = 5;
    localparam logic [3:0] PSMS_STRAP_RST  = 4'h0;
    localparam logic [15:0] PSMS_REG_RST   = 16'h0000;
    // ==========================================================
    // Timing
    localparam int         PSMS_CLK_MHZ      = 50;
    localparam int         PSMS_QUIET_US     = 30;   // Settle time after reset
    localparam int         PSMS_QUIET_CYC    = PSMS_QUIET_US * PSMS_CLK_MHZ;
    localparam int         PSMS_LINK_CYC_MIN = 1;
endpackage : psms_pkg

/* File: src/psms_regfile.sv */
// Register storage for the serial management port slave.
// Assumes writes and reads come from one clock domain; read data is registered.
`timescale 1ns/1ps
module psms_regfile (
    input  wire logic                                clk,
    input  wire logic                                rst,
    input  wire logic                                wr_en,
    input  wire logic [psms_pkg::PSMS_REG_AW-1:0]     wr_addr,
    input  wire logic [psms_pkg::PSMS_DATA_BITS-1:0]  wr_data,
    input  wire logic [psms_pkg::PSMS_REG_AW-1:0]     rd_addr,
    output logic      [psms_pkg::PSMS_DATA_BITS-1:0]  rd_data
);
    import psms_pkg::*;
    // ==========================================================
    // Storage array
    logic [PSMS_DATA_BITS-1:0] mem_q [PSMS_REG_NUM];

    // One word per register, reset so reads are defined
    genvar g;
    generate
        for (g = 0; g < PSMS_REG_NUM; g++) begin : g_word
            always_ff @(posedge clk) begin
                if (rst) begin
                    mem_q[g] <= PSMS_REG_RST;
                end else if (wr_en && wr_addr == PSMS_REG_AW'(g)) begin
                    mem_q[g] <= wr_data;
                end
            end
        end
    endgenerate

    // Registered read port
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data <= PSMS_REG_RST;
        end else begin
            rd_data <= mem_q[rd_addr];
        end
    end
endmodule : psms_regfile

/* File: src/psms_slave.sv */
// Serial management port slave: frame decoder on the management clock,
// register file on the system clock. Assumes an external pull-up on the data line
// and a controller that keeps its clock under 25 MHz.
//
// Overview of operation
// - Accept short and extended frame formats
// - Frame state survives stopped management clock
// - Data sampled on rising management clock
// - Drive line only for read data
// - Latch 4-bit address from straps
// - Register field selects one of 32
// - Start pattern zero then one, or two zeros for extended frames
// - Fixed field order per frame
// - First turnaround bit left undriven
// - Read drives zero then data, MSB first
`timescale 1ns/1ps
module psms_slave (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [3:0]  strap_addr,
    input  wire logic        mgmt_clk,
    input  wire logic        mgmt_data_i,
    output logic             mgmt_data_o,
    output logic             mgmt_data_oe,
    output logic [3:0]       station_addr,
    output logic             mgmt_ready
);
    import psms_pkg::*;

    // ==========================================================
    // Reset and strap capture (system domain)
    logic [3:0]  strap_s1_q, strap_s2_q;
    logic        strap_take_q;
    logic [15:0] quiet_cnt_q;

    // Straps synchronised, then caught on the first clock after reset
    always_ff @(posedge clk) begin
        strap_s1_q <= strap_addr;
        strap_s2_q <= strap_s1_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            strap_take_q <= 1'b1;
            station_addr <= PSMS_STRAP_RST;
        end else if (strap_take_q) begin
            strap_take_q <= 1'b0;
            station_addr <= strap_s2_q;
        end
    end

    // Ready flag only informs the controller side; it gates nothing
    always_ff @(posedge clk) begin
        if (rst) begin
            quiet_cnt_q <= '0;
            mgmt_ready  <= 1'b0;
        end else if (quiet_cnt_q != 16'(PSMS_QUIET_CYC)) begin
            quiet_cnt_q <= quiet_cnt_q + 16'h0001;
        end else begin
            mgmt_ready  <= 1'b1;
        end
    end

    // Reset into link domain; the link clock may stop so it is held until seen
    logic lrst_s1_q, lrst_q;
    always_ff @(posedge mgmt_clk or posedge rst) begin
        if (rst) begin
            lrst_s1_q <= 1'b1;
            lrst_q    <= 1'b1;
        end else begin
            lrst_s1_q <= 1'b0;
            lrst_q    <= lrst_s1_q;
        end
    end

    // Address into link domain: stable long before the first frame
    logic [3:0] addr_l1_q, addr_l2_q;
    always_ff @(posedge mgmt_clk) begin
        addr_l1_q <= station_addr;
        addr_l2_q <= addr_l1_q;
    end

    // ==========================================================
    // Frame decoder (link domain, rising edge)
    typedef enum {PSMS_IDLE, PSMS_HDR, PSMS_TA, PSMS_DATA} psms_state_t;
    psms_state_t  st_q;
    logic [4:0]   cnt_q;
    logic [13:0]  sh_q;
    logic         prev_q;
    logic         is_rd_q, mine_q;
    logic [15:0]  out_q;
    logic [15:0]  wsh_q;
    logic [15:0]  rd_sync_q;

    // Decoded header fields once fourteen bits are in
    wire [13:0] hdr      = {sh_q[12:0], mgmt_data_i};
    wire [1:0]  hdr_st   = hdr[13:12];
    wire [1:0]  hdr_op   = hdr[11:10];
    wire [4:0]  hdr_phy  = hdr[9:5];
    wire [4:0]  hdr_reg  = hdr[4:0];
    wire        addr_hit = hdr_phy == {1'b0, addr_l2_q};
    wire        c22_rd   = hdr_st == PSMS_START_PAT && hdr_op == PSMS_OP_READ;
    wire        c22_wr   = hdr_st == PSMS_START_PAT && hdr_op == PSMS_OP_WRITE;
    wire        c45_rd   = hdr_st == PSMS_C45_START
                           && (hdr_op == PSMS_C45_READ || hdr_op == PSMS_C45_RDINC);
    wire        c45_wr   = hdr_st == PSMS_C45_START
                           && (hdr_op == PSMS_C45_WRITE || hdr_op == PSMS_C45_ADDR);
    wire        hdr_ok   = addr_hit && (c22_rd || c22_wr || c45_rd || c45_wr);
    wire        frm_beg  = prev_q && !mgmt_data_i;

    // Write handoff toggle towards system domain
    logic       wr_tgl_q;
    logic [4:0] wr_addr_l_q;
    logic [4:0] rd_addr_l_q;

    // All state holds while the clock is stopped, no timeout needed
    always_ff @(posedge mgmt_clk) begin
        if (lrst_q) begin
            st_q <= PSMS_IDLE;
            cnt_q <= '0;
            sh_q <= '0;
            prev_q <= 1'b1;
            is_rd_q <= 1'b0;
            mine_q <= 1'b0;
            out_q <= '0;
            wsh_q <= '0;
            wr_addr_l_q <= '0;
            rd_addr_l_q <= '0;
        end else begin
            prev_q <= mgmt_data_i;
            case (st_q)
                PSMS_IDLE: begin
                    // First zero after a one opens the frame
                    if (frm_beg) begin
                        st_q  <= PSMS_HDR;
                        sh_q  <= 14'h0000;
                        cnt_q <= 5'h01;
                    end
                end
                PSMS_HDR: begin
                    sh_q  <= hdr;
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == 5'(PSMS_HDR_BITS - 1)) begin
                        st_q        <= PSMS_TA;
                        cnt_q       <= '0;
                        mine_q      <= hdr_ok;
                        is_rd_q     <= c22_rd || c45_rd;
                        rd_addr_l_q <= hdr_reg;
                        wr_addr_l_q <= hdr_reg;
                    end
                end
                PSMS_TA: begin
                    // Word caught at the first turnaround edge has settled; load it now
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q != 5'h00) begin
                        out_q <= rd_sync_q;
                        st_q  <= PSMS_DATA;
                        cnt_q <= '0;
                    end
                end
                PSMS_DATA: begin
                    cnt_q <= cnt_q + 5'h01;
                    out_q <= {out_q[14:0], 1'b0};
                    wsh_q <= {wsh_q[14:0], mgmt_data_i};
                    if (cnt_q == 5'(PSMS_DATA_BITS - 1)) begin
                        st_q <= PSMS_IDLE;
                        prev_q <= 1'b0;                           // Needs idle high first
                    end
                end
                default: st_q <= PSMS_IDLE;
            endcase
        end
    end

    // Write toggle clears with the system reset itself, so the crossing never
    // sees a stale toggle while a stopped link clock still holds the old value
    wire wr_done = st_q == PSMS_DATA && cnt_q == 5'(PSMS_DATA_BITS - 1)
                   && mine_q && !is_rd_q;
    always_ff @(posedge mgmt_clk or posedge rst) begin
        if (rst) begin
            wr_tgl_q <= 1'b0;
        end else if (!lrst_q && wr_done) begin
            wr_tgl_q <= ~wr_tgl_q;
        end
    end

    // Data line driven on falling edge so it is stable at the next rising edge
    // Released at once by reset, even while the link clock is stopped
    logic drv_q, bit_q;
    always_ff @(negedge mgmt_clk or posedge rst) begin
        if (rst) begin
            drv_q <= 1'b0;
            bit_q <= 1'b1;
        end else if (lrst_q) begin
            drv_q <= 1'b0;
            bit_q <= 1'b1;
        end else begin
            drv_q <= mine_q && is_rd_q
                     && ((st_q == PSMS_TA && cnt_q == 5'h01) || st_q == PSMS_DATA);
            bit_q <= (st_q == PSMS_TA) ? 1'b0 : out_q[15];
        end
    end
    assign mgmt_data_oe = drv_q;
    assign mgmt_data_o  = bit_q;

    // ==========================================================
    // Crossing to system domain and register access
    logic [2:0]  wtg_q;
    logic [15:0] rd_word;
    logic [4:0]  rad_s1_q, rad_s2_q;

    // Toggle synchroniser; write word and address are stable for a whole frame
    always_ff @(posedge clk) begin
        if (rst) begin
            wtg_q <= '0;
        end else begin
            wtg_q <= {wtg_q[1:0], wr_tgl_q};
        end
    end
    wire sys_wr = wtg_q[2] ^ wtg_q[1];

    // Address settles during the turnaround pause of a slow link clock
    always_ff @(posedge clk) begin
        rad_s1_q <= rd_addr_l_q;
        rad_s2_q <= rad_s1_q;
    end

    // Link side samples the stable registered word one bit time later
    always_ff @(posedge mgmt_clk) begin
        rd_sync_q <= rd_word;
    end

    psms_regfile u_regs (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (sys_wr),
        .wr_addr (wr_addr_l_q),
        .wr_data (wsh_q),
        .rd_addr (rad_s2_q),
        .rd_data (rd_word)
    );
endmodule : psms_slave

/* File: tb/psms_ctl_model.sv */
// Management controller model: sources the clock and drives or releases data.
// Assumes the bench resolves the shared line with a pull-up.
`timescale 1ns/1ps
module psms_ctl_model (
    output logic      mgmt_clk,
    output logic      ctl_o,
    output logic      ctl_oe,
    input  wire logic mdio
);
    // ============================================================
    // Clock stands still low between frames
    initial begin
        mgmt_clk = 1'b0;
        ctl_o    = 1'b1;
        ctl_oe   = 1'b0;
    end
    // Launch just after the falling edge, sample on the rising edge
    task automatic bit_cyc(input logic drv, input logic val, input int hp, output logic smp);
        ctl_oe = drv;
        ctl_o  = val;
        #hp mgmt_clk = 1'b1;
        smp    = mdio;
        #hp mgmt_clk = 1'b0;
    endtask : bit_cyc
    // Reads stretch turnaround so the read address can cross into the system clock and the word back
    task automatic frame(input logic [13:0] hdr, input logic [15:0] wd, input int hp,
                         output logic [15:0] rd, output logic ta);
        logic s;
        logic rdop;
        int   h;
        h    = (hp < 20) ? 20 : hp;
        rdop = hdr[11] && !(hdr[13:12] == 2'h1 && hdr[10]);
        for (int i = 0; i < 32; i++) bit_cyc(1'b0, 1'b1, h, s);
        for (int i = 13; i >= 0; i--) bit_cyc(1'b1, hdr[i], h, s);
        bit_cyc(!rdop, 1'b1, rdop ? 3 * h : h, s);
        bit_cyc(!rdop, 1'b0, rdop ? 3 * h : h, ta);
        for (int i = 15; i >= 0; i--) bit_cyc(!rdop, wd[i], h, rd[i]);
        ctl_oe = 1'b0;
    endtask : frame
endmodule : psms_ctl_model

/* File: tb/psms_slave_monitor.sv */
// Checker for the management slave, on its ports only.
// Assumes 32-bit frames and a management clock that stops between them.
`timescale 1ns/1ps
module psms_monitor
    import psms_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [3:0] strap_addr,
    input wire logic       mgmt_clk,
    input wire logic       mgmt_data_i,
    input wire logic       mgmt_data_o,
    input wire logic       mgmt_data_oe,
    input wire logic [3:0] station_addr,
    input wire logic       mgmt_ready
);
    logic [5:0]  cnt_q = 6'h00;
    logic        last_q = 1'b0;
    logic [13:0] hdr_q = 14'h0000;
    logic [10:0] up_q;
    // Header of a read, short or extended form, aimed at this station
    wire         rd_op  = hdr_q[13:10] == 4'h6 || hdr_q[13:11] == 3'h1;
    wire         rd_hit = rd_op && hdr_q[9:5] == {1'h0, station_addr};
    // ============================================================
    // Bit position in the frame; a high-to-low step from idle opens it
    always_ff @(posedge mgmt_clk) begin
        last_q <= mgmt_data_i;
        hdr_q  <= (cnt_q < 6'h0E) ? {hdr_q[12:0], mgmt_data_i} : hdr_q;
        cnt_q  <= (cnt_q == 6'h1F) ? 6'h00 : (cnt_q != 6'h00 || (last_q && !mgmt_data_i))
                  ? cnt_q + 6'h01 : 6'h00;
    end
    // Cycles since reset release, saturating
    always_ff @(posedge clk) begin
        up_q <= rst ? 11'h000 : (up_q == 11'h7FF) ? up_q : up_q + 11'h001;
    end
    // ============================================================
    sequence s_drive8;
        mgmt_data_oe [*8];
    endsequence
    ta_free_a: assert property (@(posedge mgmt_clk) disable iff (rst)
        cnt_q == 6'h0E |-> !mgmt_data_oe) else $error("line driven in first turnaround bit");
    ta_zero_a: assert property (@(posedge mgmt_clk) disable iff (rst)
        cnt_q == 6'h0F && rd_hit |-> mgmt_data_oe && !mgmt_data_o) else $error("no zero in turnaround");
    rd_drive_a: assert property (@(posedge mgmt_clk) disable iff (rst)
        cnt_q == 6'h10 && rd_hit |-> s_drive8 ##1 s_drive8) else $error("read data not driven");
    miss_quiet_a: assert property (@(posedge mgmt_clk) disable iff (rst)
        cnt_q > 6'h0E && !rd_hit |-> !mgmt_data_oe) else $error("line driven on foreign frame");
    idle_quiet_a: assert property (@(posedge mgmt_clk) disable iff (rst)
        cnt_q < 6'h0E |-> !mgmt_data_oe) else $error("line driven outside read data");
    strap_hold_a: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) && !$past(rst, 2) |-> $stable(station_addr)) else $error("address moved");
    ready_time_a: assert property (@(posedge clk) disable iff (rst)
        (up_q < PSMS_QUIET_CYC - 2 |-> !mgmt_ready) and (up_q > PSMS_QUIET_CYC + 2 |-> mgmt_ready))
        else $error("ready at wrong time");
    fall_launch_a: assert property (@(posedge clk) disable iff (rst)
        mgmt_clk && $past(mgmt_clk) |-> $stable(mgmt_data_oe) && $stable(mgmt_data_o))
        else $error("output moved while clock high");
endmodule : psms_monitor

bind psms_slave psms_monitor i_psms_monitor (.clk(clk), .rst(rst), .strap_addr(strap_addr),
    .mgmt_clk(mgmt_clk), .mgmt_data_i(mgmt_data_i), .mgmt_data_o(mgmt_data_o),
    .mgmt_data_oe(mgmt_data_oe), .station_addr(station_addr), .mgmt_ready(mgmt_ready));

/* File: tb/tb.sv */
// Bench for the management slave: controller model on the line, scenario tasks.
// Assumes a 50 MHz system clock and a pull-up on the shared data line.
`timescale 1ns/1ps
module tb;
    import psms_pkg::*;
    logic        clk = 1'b0;
    logic        rst;
    logic [3:0]  strap_addr = 4'h5;
    logic        mgmt_clk;
    logic        ctl_o;
    logic        ctl_oe;
    logic        mgmt_data_o;
    logic        mgmt_data_oe;
    logic        mgmt_ready;
    logic [3:0]  station_addr;
    logic [15:0] rd;
    logic        ta;
    int          err_total = 0;
    int          samples_checked = 0;
    // Released line floats high through the pull-up
    wire mdio = mgmt_data_oe ? mgmt_data_o : ctl_oe ? ctl_o : 1'b1;
    wire [4:0] me = {1'b0, strap_addr};
    always #10 clk = ~clk;
    psms_slave i_psms_slave (.clk(clk), .rst(rst), .strap_addr(strap_addr),
        .mgmt_clk(mgmt_clk), .mgmt_data_i(mdio), .mgmt_data_o(mgmt_data_o),
        .mgmt_data_oe(mgmt_data_oe), .station_addr(station_addr), .mgmt_ready(mgmt_ready));
    psms_ctl_model i_psms_ctl_model (.mgmt_clk(mgmt_clk), .ctl_o(ctl_o), .ctl_oe(ctl_oe),
        .mdio(mdio));
    // ============================================================
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Pause with the management clock stopped, then one frame
    task automatic xfer(input logic [1:0] st, input logic [1:0] op, input logic [4:0] phy,
                        input logic [4:0] rg, input logic [15:0] wd, input int hp);
        #777;
        i_psms_ctl_model.frame({st, op, phy, rg}, wd, hp, rd, ta);
    endtask : xfer
    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out
    // ============================================================
    task automatic t_reset();
        check("addr", {12'h000, station_addr}, 16'h0005);
        check("early", {15'h0000, mgmt_ready}, 16'h0000);
        for (int i = 0; i < 2000 && mgmt_ready !== 1'b1; i++) @(posedge clk);
        check("ready", {15'h0000, mgmt_ready}, 16'h0001);
    endtask : t_reset
    task automatic t_wr_rd();
        logic [4:0] r[3] = '{5'h00, 5'h1F, 5'h0A};
        foreach (r[k]) begin
            xfer(PSMS_START_PAT, PSMS_OP_WRITE, me, r[k], 16'hA5C3 ^ r[k], 16);
            xfer(PSMS_START_PAT, PSMS_OP_READ, me, r[k], 16'h0000, 16 + 16 * k);
            check("rdata", rd, 16'hA5C3 ^ r[k]);
            check("ta", {15'h0000, ta}, 16'h0000);
        end
    endtask : t_wr_rd
    task automatic t_refuse();
        xfer(PSMS_START_PAT, PSMS_OP_WRITE, {1'b1, strap_addr}, 5'h00, 16'h1111, 16);
        xfer(PSMS_START_PAT, PSMS_OP_WRITE, {1'b0, ~strap_addr}, 5'h00, 16'h2222, 16);
        xfer(PSMS_START_PAT, 2'h3, me, 5'h00, 16'h3333, 16);
        xfer(PSMS_START_PAT, 2'h0, me, 5'h00, 16'h4444, 16);
        xfer(PSMS_START_PAT, PSMS_OP_READ, {1'b0, ~strap_addr}, 5'h00, 16'h0000, 16);
        check("foreign", rd, 16'hFFFF);
        check("foreign ta", {15'h0000, ta}, 16'h0001);
        xfer(PSMS_START_PAT, PSMS_OP_READ, me, 5'h00, 16'h0000, 16);
        check("kept", rd, 16'hA5C3);
    endtask : t_refuse
    task automatic t_ext();
        xfer(PSMS_C45_START, PSMS_C45_ADDR, me, 5'h03, 16'h0003, 16);
        xfer(PSMS_C45_START, PSMS_C45_WRITE, me, 5'h03, 16'h1234, 16);
        xfer(PSMS_C45_START, PSMS_C45_READ, me, 5'h03, 16'h0000, 16);
        check("ext", rd, 16'h1234);
        xfer(PSMS_C45_START, PSMS_C45_RDINC, me, 5'h03, 16'h0000, 16);
        check("extinc", rd, 16'h1234);
        xfer(PSMS_START_PAT, PSMS_OP_READ, me, 5'h03, 16'h0000, 16);
        check("short", rd, 16'h1234);
    endtask : t_ext
    // Straps move after the latch; a second reset then takes the new address
    task automatic t_strap();
        @(posedge clk);
        strap_addr <= 4'hA;
        repeat (4) @(posedge clk);
        check("held", {12'h000, station_addr}, 16'h0005);
        xfer(PSMS_START_PAT, PSMS_OP_READ, 5'h05, 5'h03, 16'h0000, 16);
        check("old phy", rd, 16'h1234);
        @(posedge clk);
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        check("relatch", {12'h000, station_addr}, 16'h000A);
        for (int i = 0; i < 2000 && mgmt_ready !== 1'b1; i++) @(posedge clk);
        check("ready2", {15'h0000, mgmt_ready}, 16'h0001);
        xfer(PSMS_START_PAT, PSMS_OP_READ, 5'h0A, 5'h03, 16'h0000, 16);
        check("cleared", rd, PSMS_REG_RST);
        xfer(PSMS_START_PAT, PSMS_OP_READ, 5'h05, 5'h03, 16'h0000, 16);
        check("old gone", rd, 16'hFFFF);
    endtask : t_strap
    // ============================================================
    // Reset rises at time zero so the link-side asynchronous clears see an edge
    initial begin
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        t_reset();
        t_wr_rd();
        t_refuse();
        t_ext();
        t_strap();
        close_out();
    end
    // Watchdog far beyond the expected run of under 150 us
    initial begin
        #500000;
        err_total++;
        close_out();
    end
endmodule : tb
